// ---- mprs_consts.svh ----
// constants for the mirror park reset sequencer
// assumes a 100 MHz reference clock; included by bare name
`ifndef MPRS_CONSTS_SVH
`define MPRS_CONSTS_SVH
`define MPRS_CLK_MHZ 100
`define MPRS_FAST_PARK_US 32
`define MPRS_NORMAL_PARK_US 500
`define MPRS_HOST_WAIT_MS 500
`define MPRS_LEVEL_HOLD_MS 200
`define MPRS_INIT_CYCLES 1000
`define MPRS_GPIO_W 20
`endif

// ---- mprs_pkg.sv ----
// types for the mirror park reset sequencer
// no assumptions beyond the constants header
package mprs_pkg;
  typedef enum logic [5:0] {
    MPRS_RESET = 6'h01,
    MPRS_INIT = 6'h02,
    MPRS_RUN = 6'h04,
    MPRS_NPARK = 6'h08,
    MPRS_FPARK = 6'h10,
    MPRS_PARKED = 6'h20
  } mprs_state_e;
endpackage

// ---- mprs_sequencer.sv ----
// reset, self-configuration and mirror parking sequencer
// assumes all inputs synchronous to REF_CLK_I; outside party keeps its timing
`timescale 1ns/1ns
`default_nettype none
`include "mprs_consts.svh"

// Function
// RQ1: outside holds fast park high for normal run, before reset release.
// RQ2: outside drives fast park low 32 us before removing power.
// RQ3: fast park only for imminent power loss; normal park preferred.
// RQ4: normal park from projection_on low lasts up to 500 us.
// RQ5: outside keeps supplies and reset high until normal park completes.
// RQ6: self-configuration begins on rising edge of power-on reset.
// RQ7: serial port pins and twenty GPIO pins tri-stated during reset.
// RQ8: light selects and mirror driver enable forced low during reset.
// RQ9: all outputs inactive while reset input asserted.
// RQ10: host waits 500 ms after reset and fast park high before I2C.
// RQ11: mirror driver enable driven low after park, before mirror power off.
// RQ12: after reset, software may set unused GPIO pins as outputs.
// RQ13: projection_on low parks without power down; levels held 200 ms.
// RQ14: host interrupt shows init in progress and completion; tri-state in reset.
// RQ15: light selects stay low for the whole auto-initialization.
// RQ16: fast park request abandons a normal park and parks at once.
module mprs_sequencer
  import mprs_pkg::*;
#(
  parameter int FAST_PARK_CYC = `MPRS_FAST_PARK_US * `MPRS_CLK_MHZ,
  parameter int NORMAL_PARK_CYC = `MPRS_NORMAL_PARK_US * `MPRS_CLK_MHZ,
  parameter int INIT_CYC = `MPRS_INIT_CYCLES,
  parameter int HOST_WAIT_CYC = `MPRS_HOST_WAIT_MS * 1000 * `MPRS_CLK_MHZ
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic POWER_ON_RESET_N_I,
  input wire logic FAST_PARK_N_I,
  input wire logic PROJECTION_ON_I,
  input wire logic [1:0] LIGHT_SELECT_REQ_I,
  input wire logic SERIAL_PORT_CLOCK_REQ_I,
  input wire logic SERIAL_PORT_DATA_OUT_REQ_I,
  input wire logic SERIAL_PORT_SELECT_0_N_REQ_I,
  input wire logic SERIAL_PORT_SELECT_1_N_REQ_I,
  input wire logic [`MPRS_GPIO_W-1:0] GPIO_OUT_REQ_I,
  input wire logic [`MPRS_GPIO_W-1:0] GPIO_DIR_OUT_I,
  output logic LIGHT_SOURCE_SELECT_LO_O,
  output logic LIGHT_SOURCE_SELECT_HI_O,
  output logic MIRROR_DRIVER_ENABLE_O,
  output logic SERIAL_PORT_CLOCK_O,
  output logic SERIAL_PORT_DATA_OUT_O,
  output logic SERIAL_PORT_SELECT_0_N_O,
  output logic SERIAL_PORT_SELECT_1_N_O,
  output logic SERIAL_PORT_OE_O,
  output logic [`MPRS_GPIO_W-1:0] GPIO_O,
  output logic [`MPRS_GPIO_W-1:0] GPIO_OE_O,
  output logic HOST_IRQ_O,
  output logic HOST_IRQ_OE_O,
  output logic PARKED_O,
  output logic HOST_READY_O
);

  initial begin
    if (FAST_PARK_CYC < 1 || NORMAL_PARK_CYC <= FAST_PARK_CYC || INIT_CYC < 1 || HOST_WAIT_CYC < 1) begin
      $error("mprs_sequencer: bad timing parameters");
    end
  end

  localparam int CW = 32;

  mprs_state_e state;
  mprs_state_e next_state;
  logic [CW-1:0] timer;
  logic [CW-1:0] host_timer;
  logic por_q;
  logic in_reset;
  logic timer_done;

  assign in_reset = !POWER_ON_RESET_N_I;
  assign timer_done = (timer == '0);

  //////////////////////////////////////////////////////////////////////////////
  // sequencing state machine
  always_comb begin
    next_state = state;
    case (state)
      MPRS_RESET: begin
        // por_q high means reset was seen last edge, so this is the rising edge
        if (!in_reset && por_q) begin
          next_state = MPRS_INIT; // see RQ6
        end
      end
      MPRS_INIT: begin
        if (timer_done) begin
          next_state = MPRS_RUN;
        end
      end
      MPRS_RUN: begin
        if (!FAST_PARK_N_I) begin
          next_state = MPRS_FPARK;
        end else if (!PROJECTION_ON_I) begin
          next_state = MPRS_NPARK; // see RQ13
        end
      end
      MPRS_NPARK: begin
        if (!FAST_PARK_N_I) begin
          next_state = MPRS_FPARK; // see RQ16
        end else if (timer_done) begin
          next_state = MPRS_PARKED; // see RQ4
        end
      end
      MPRS_FPARK: begin
        if (timer_done) begin
          next_state = MPRS_PARKED;
        end
      end
      MPRS_PARKED: begin
        // resume only when both park requests are released
        if (FAST_PARK_N_I && PROJECTION_ON_I) begin
          next_state = MPRS_INIT;
        end
      end
      default: next_state = MPRS_RESET;
    endcase
    if (in_reset) begin
      next_state = MPRS_RESET; // see RQ9
    end
  end

  // state register; por_q remembers the reset level for edge detection
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= MPRS_RESET;
      por_q <= 1'b1;
    end else begin
      state <= next_state;
      por_q <= in_reset;
    end
  end

  // shared phase timer, reloaded on every state entry
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      timer <= '0;
    end else if (next_state != state) begin
      case (next_state)
        MPRS_INIT: timer <= CW'(INIT_CYC - 1);
        MPRS_NPARK: timer <= CW'(NORMAL_PARK_CYC - 1);
        MPRS_FPARK: timer <= CW'(FAST_PARK_CYC - 1); // see RQ16
        default: timer <= '0;
      endcase
    end else if (!timer_done) begin
      timer <= timer - 1'b1;
    end
  end

  // quiet window before the host may talk; status only, not enforced
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      host_timer <= '0;
      HOST_READY_O <= 1'b0;
    end else if (in_reset || !FAST_PARK_N_I) begin
      host_timer <= '0; // see RQ10
      HOST_READY_O <= 1'b0;
    end else if (host_timer != CW'(HOST_WAIT_CYC - 1)) begin
      host_timer <= host_timer + 1'b1;
      HOST_READY_O <= 1'b0;
    end else begin
      HOST_READY_O <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered pin drivers; light selects inactive outside run, mirror enable low only in reset and parked
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      LIGHT_SOURCE_SELECT_LO_O <= 1'b0;
      LIGHT_SOURCE_SELECT_HI_O <= 1'b0;
      MIRROR_DRIVER_ENABLE_O <= 1'b0;
      PARKED_O <= 1'b0;
    end else begin
      // light stays dark through init and parking
      LIGHT_SOURCE_SELECT_LO_O <= (next_state == MPRS_RUN) & LIGHT_SELECT_REQ_I[0]; // see RQ8, RQ15
      LIGHT_SOURCE_SELECT_HI_O <= (next_state == MPRS_RUN) & LIGHT_SELECT_REQ_I[1]; // see RQ8, RQ15
      // drops in reset or after park timer ends, mirrors still powered per outside
      MIRROR_DRIVER_ENABLE_O <= (next_state == MPRS_INIT) || (next_state == MPRS_RUN) ||
        (next_state == MPRS_NPARK) || (next_state == MPRS_FPARK); // see RQ8, RQ11
      PARKED_O <= (next_state == MPRS_PARKED);
    end
  end

  // serial port and gpio released from tri-state only after reset
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      SERIAL_PORT_OE_O <= 1'b0;
      SERIAL_PORT_CLOCK_O <= 1'b0;
      SERIAL_PORT_DATA_OUT_O <= 1'b0;
      SERIAL_PORT_SELECT_0_N_O <= 1'b1;
      SERIAL_PORT_SELECT_1_N_O <= 1'b1;
      GPIO_O <= '0;
      GPIO_OE_O <= '0;
    end else begin
      SERIAL_PORT_OE_O <= (next_state != MPRS_RESET); // see RQ7
      SERIAL_PORT_CLOCK_O <= SERIAL_PORT_CLOCK_REQ_I;
      SERIAL_PORT_DATA_OUT_O <= SERIAL_PORT_DATA_OUT_REQ_I;
      SERIAL_PORT_SELECT_0_N_O <= SERIAL_PORT_SELECT_0_N_REQ_I;
      SERIAL_PORT_SELECT_1_N_O <= SERIAL_PORT_SELECT_1_N_REQ_I;
      GPIO_O <= GPIO_OUT_REQ_I;
      // unused pins may be turned to outputs once out of reset
      GPIO_OE_O <= (next_state == MPRS_RESET) ? '0 : GPIO_DIR_OUT_I; // see RQ7, RQ12
    end
  end

  // interrupt low while initializing, released to pullup when done
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      HOST_IRQ_O <= 1'b0;
      HOST_IRQ_OE_O <= 1'b0;
    end else begin
      HOST_IRQ_O <= 1'b0;
      HOST_IRQ_OE_O <= (next_state == MPRS_INIT); // see RQ14
    end
  end

endmodule
`default_nettype wire

// ---- mprs_host_model.sv ----
// host and power manager levels seen by the sequencer
// assumes the bench sets the requests with nonblocking writes on the falling edge
`timescale 1ns/1ns
`default_nettype none
module mprs_host_model (
  input wire logic clk_i,
  input wire logic por_req_i,
  input wire logic fast_req_i,
  input wire logic proj_req_i,
  output var logic power_on_reset_n_o,
  output var logic fast_park_n_o,
  output var logic projection_on_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // levels move on the falling edge, one cycle behind the requests
  initial begin
    power_on_reset_n_o = 1'b0;
    fast_park_n_o = 1'b1;
    projection_on_o = 1'b1;
  end
  always @(negedge clk_i) begin
    fast_park_n_o <= fast_req_i;
    // rises only while fast park is high, then held through parks
    power_on_reset_n_o <= por_req_i & (power_on_reset_n_o | fast_park_n_o);
    projection_on_o <= proj_req_i;
  end
endmodule
`default_nettype wire

// ---- mprs_sequencer_props.sv ----
// port checker for the mirror park reset sequencer
// assumes a bind onto mprs_sequencer with shortened counts
`timescale 1ns/1ns
`default_nettype none
`include "mprs_consts.svh"
module mprs_seq_props #(
  parameter int FAST_PARK_CYC = 10,
  parameter int NORMAL_PARK_CYC = 50,
  parameter int INIT_CYC = 20
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic POWER_ON_RESET_N_I,
  input wire logic FAST_PARK_N_I,
  input wire logic PROJECTION_ON_I,
  input wire logic LIGHT_SOURCE_SELECT_LO_O,
  input wire logic LIGHT_SOURCE_SELECT_HI_O,
  input wire logic MIRROR_DRIVER_ENABLE_O,
  input wire logic SERIAL_PORT_OE_O,
  input wire logic [`MPRS_GPIO_W-1:0] GPIO_OE_O,
  input wire logic HOST_IRQ_OE_O,
  input wire logic PARKED_O,
  input wire logic HOST_READY_O
);
  // windows leave slack for the registered state
  localparam int INIT_LO = INIT_CYC - 1;
  localparam int INIT_HI = INIT_CYC + 3;
  localparam int NP_LO = NORMAL_PARK_CYC - 1;
  localparam int NP_HI = NORMAL_PARK_CYC + 3;
  localparam int FP_LO = FAST_PARK_CYC - 1;
  localparam int FP_HI = FAST_PARK_CYC + 3;
  wire logic run = MIRROR_DRIVER_ENABLE_O && !HOST_IRQ_OE_O;
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);
  ////////////////////////////////////////////////////////////////////////////////
  AST_TRISTATE: assert property (!POWER_ON_RESET_N_I |=> !SERIAL_PORT_OE_O && GPIO_OE_O == '0)
    else $error("pins driven in reset");
  AST_FORCE_LOW: assert property (!POWER_ON_RESET_N_I |=> !LIGHT_SOURCE_SELECT_LO_O && !LIGHT_SOURCE_SELECT_HI_O
    && !MIRROR_DRIVER_ENABLE_O) else $error("select or enable high in reset");
  AST_INACTIVE: assert property (!POWER_ON_RESET_N_I || !FAST_PARK_N_I |=> !HOST_READY_O && !HOST_IRQ_OE_O)
    else $error("status active in reset");
  AST_START: assert property ($rose(POWER_ON_RESET_N_I) && FAST_PARK_N_I |=> HOST_IRQ_OE_O && MIRROR_DRIVER_ENABLE_O)
    else $error("no start on reset release");
  AST_INIT_DARK: assert property (HOST_IRQ_OE_O |-> !LIGHT_SOURCE_SELECT_LO_O && !LIGHT_SOURCE_SELECT_HI_O)
    else $error("light on during init");
  AST_INIT_LEN: assert property ($rose(HOST_IRQ_OE_O) |-> ##[INIT_LO:INIT_HI] $fell(HOST_IRQ_OE_O))
    else $error("init length wrong");
  // a fast park may cut a normal park short, so that case is left out
  AST_NPARK: assert property (disable iff (RST_I || !FAST_PARK_N_I) $fell(PROJECTION_ON_I) && run && !PARKED_O
    |-> ##[NP_LO:NP_HI] $rose(PARKED_O) && !MIRROR_DRIVER_ENABLE_O) else $error("normal park wrong");
  AST_FPARK: assert property ($fell(FAST_PARK_N_I) && run |-> ##[FP_LO:FP_HI] $rose(PARKED_O))
    else $error("fast park wrong");
  C_PARK: cover property ($rose(PARKED_O));
  C_INIT: cover property ($fell(HOST_IRQ_OE_O));
  C_READY: cover property ($rose(HOST_READY_O));
endmodule
bind mprs_sequencer mprs_seq_props #(.FAST_PARK_CYC(FAST_PARK_CYC), .NORMAL_PARK_CYC(NORMAL_PARK_CYC),
  .INIT_CYC(INIT_CYC)) i_props (.*);
`default_nettype wire

// ---- mprs_sequencer_tb.sv ----
// self-checking bench for the mirror park reset sequencer
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/1ns
`default_nettype none
module mprs_sequencer_tb;
  localparam int INIT = 20;
  localparam int NP = 50;
  localparam int FP = 10;
  logic clk = 1'b0, rst = 1'b1, por_req = 1'b0, fast_req = 1'b1, proj_req = 1'b1;
  logic [19:0] greq = 20'hA5A5A, gdir = 20'hFFFFF, gpio, goe;
  logic lo, hi, den, soe, irq, ioe, parked, ready;
  logic [1:0] lsel = 2'h3;
  logic [3:0] sreq = 4'hA;
  wire logic [3:0] sout;
  wire logic por_n, fast_n, proj;
  int err_count = 0, comparisons = 0, n;
  always #5 clk = ~clk;
  mprs_host_model i_host (.clk_i(clk), .por_req_i(por_req), .fast_req_i(fast_req), .proj_req_i(proj_req),
    .power_on_reset_n_o(por_n), .fast_park_n_o(fast_n), .projection_on_o(proj));
  mprs_sequencer #(.FAST_PARK_CYC(FP), .NORMAL_PARK_CYC(NP), .INIT_CYC(INIT), .HOST_WAIT_CYC(100)) i_dut (
    .REF_CLK_I(clk), .RST_I(rst), .POWER_ON_RESET_N_I(por_n), .FAST_PARK_N_I(fast_n), .PROJECTION_ON_I(proj),
    .LIGHT_SELECT_REQ_I(lsel), .SERIAL_PORT_CLOCK_REQ_I(sreq[3]), .SERIAL_PORT_DATA_OUT_REQ_I(sreq[2]),
    .SERIAL_PORT_SELECT_0_N_REQ_I(sreq[1]), .SERIAL_PORT_SELECT_1_N_REQ_I(sreq[0]), .GPIO_OUT_REQ_I(greq),
    .GPIO_DIR_OUT_I(gdir), .LIGHT_SOURCE_SELECT_LO_O(lo), .LIGHT_SOURCE_SELECT_HI_O(hi),
    .MIRROR_DRIVER_ENABLE_O(den), .SERIAL_PORT_CLOCK_O(sout[3]), .SERIAL_PORT_DATA_OUT_O(sout[2]),
    .SERIAL_PORT_SELECT_0_N_O(sout[1]), .SERIAL_PORT_SELECT_1_N_O(sout[0]),
    .SERIAL_PORT_OE_O(soe), .GPIO_O(gpio), .GPIO_OE_O(goe), .HOST_IRQ_O(irq),
    .HOST_IRQ_OE_O(ioe), .PARKED_O(parked), .HOST_READY_O(ready));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // bounded wait: 0 init over, 1 parked, 2 init begun
  task automatic wait_on(input int sel, output int cyc);
    cyc = 0;
    while (!(sel == 0 ? ioe === 1'b0 : sel == 1 ? parked === 1'b1 : ioe === 1'b1)) begin
      @(negedge clk);
      cyc++;
      if (cyc > 300) begin
        err_count++;
        final_report();
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_boot();
    por_req <= 1'b1;
    wait_on(2, n);
    check({den, lo, hi, irq}, 4'h8);
    wait_on(0, n);
    check(n >= INIT - 1 && n <= INIT + 2, 1'b1);
    check({lo, hi}, 2'h3);
    check(gpio, greq);
    gdir <= 20'h0F0F0;
    lsel <= 2'h1;
    sreq <= 4'h5;
    repeat (100) @(negedge clk);
    check(goe, 20'h0F0F0);
    check({lo, hi}, 2'h2);
    check(sout, 4'h5);
    check(ready, 1'b1);
  endtask
  task automatic t_npark();
    proj_req <= 1'b0;
    wait_on(1, n);
    check(n >= NP - 1 && n <= NP + 4, 1'b1);
    check({den, lo, hi}, 3'h0);
    proj_req <= 1'b1;
    wait_on(2, n);
    wait_on(0, n);
    check(n >= INIT - 1 && n <= INIT + 2, 1'b1);
  endtask
  // fast park ten cycles into a normal park must finish on the short count
  task automatic t_abort();
    proj_req <= 1'b0;
    repeat (10) @(negedge clk);
    fast_req <= 1'b0;
    wait_on(1, n);
    check(n >= FP - 1 && n <= FP + 4, 1'b1);
    check({den, ready}, 2'h0);
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst <= 1'b0;
    repeat (3) @(negedge clk);
    check({soe, goe}, 21'h0);
    check({lo, hi, den, ioe, parked, ready}, 6'h0);
    t_boot();
    t_npark();
    t_abort();
    final_report();
  end
endmodule
`default_nettype wire
